// file: jrl_pkg.sv
// jrl_pkg: offsets, field layouts, reset values and carrier types for the receiver latency register bank
// assumes an 8-bit serial-port register interface with a 12-bit address
package jrl_pkg;

  // register offsets
  localparam logic [11:0] OFF_LINK_ENABLE   = 12'h300;
  localparam logic [11:0] OFF_SUBCLASS      = 12'h301;
  localparam logic [11:0] OFF_ARRIVAL0      = 12'h302;
  localparam logic [11:0] OFF_ARRIVAL1      = 12'h303;
  localparam logic [11:0] OFF_MF_DELAY0     = 12'h304;
  localparam logic [11:0] OFF_MF_DELAY1     = 12'h305;
  localparam logic [11:0] OFF_RELEASE0      = 12'h306;
  localparam logic [11:0] OFF_RELEASE1      = 12'h307;

  // field widths and reset values
  localparam int          FIELD_W           = 5;
  localparam int          CLASS_W           = 3;
  localparam int          EN_W              = 2;
  localparam logic [2:0]  CLASS_SUB0        = 3'h0;
  localparam logic [2:0]  CLASS_SUB1        = 3'h1;
  localparam logic [2:0]  RST_CLASS         = 3'h1;
  localparam logic [4:0]  RST_MF_DELAY      = 5'h00;
  localparam logic [4:0]  RST_RELEASE       = 5'h06;
  localparam logic [4:0]  RELEASE_MAX       = 5'h0a;
  localparam logic [1:0]  RST_ENABLE        = 2'h0;

  // register bus request
  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } jrl_req_t;

  // per-link configuration handed to the receiver logic
  typedef struct packed {
    logic       linkOn;
    logic       countFrames;
    logic [4:0] mfOffset;
    logic [4:0] releaseOffset;
  } jrl_link_cfg_t;

endpackage

// file: jrl_regs.sv
// jrl_regs: control and status register bank for the two-link serial receiver latency alignment
// assumes register requests and link tick strobes are already on sys_clk
//
// Contract
// RULE1 - enable field bit 0 turns on link 0, bit 1 turns on link 1
// RULE2 - software sets enables only after lane layer powered up and calibrated
// RULE3 - per link, read-only five-bit word-clock count from receive tick to last boundary
// RULE4 - per link, writable five-bit offset of receive tick; frames in class 1, words in 0
// RULE5 - per link, writable five-bit buffer release point in word clocks, resets to six
// RULE6 - software never programs buffer release above ten
// RULE7 - three-bit class field: 000 selects class 0, 001 class 1; reset class 1
// RULE8 - software enables links only after parameters set and clock multiplier locked
`timescale 1ns/1ps
module jrl_regs
  import jrl_pkg::*;
(
  // clock, reset, enable
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  input  wire logic          clkEn,
  // register access
  input  wire jrl_req_t      req,
  output logic [7:0]         rdata,
  output logic               rvalid,
  // link timing strobes
  input  wire logic [1:0]    localMultiframeTick,
  input  wire logic [1:0]    receiveMultiframeTick,
  input  wire logic [1:0]    lastBoundaryArrived,
  // configuration to the link logic
  output jrl_link_cfg_t      linkCfgA,
  output jrl_link_cfg_t      linkCfgB
);

  typedef struct packed {
    logic [1:0] enable;
    logic [2:0] syncClass;
    logic [4:0] mfOff0;
    logic [4:0] mfOff1;
    logic [4:0] relOff0;
    logic [4:0] relOff1;
    logic [4:0] skewCnt0;
    logic [4:0] skewCnt1;
    logic [1:0] counting;
    logic [4:0] skew0;
    logic [4:0] skew1;
    logic [7:0] rdata;
    logic       rvalid;
  } jrl_state_t;

  jrl_state_t st_reg;
  jrl_state_t st_next;

  // widen a five-bit field into a byte with zero reserved bits
  function automatic logic [7:0] pad5(input logic [4:0] v);
    return {3'h0, v};
  endfunction

  // advance one arrival counter: restart on receive tick, freeze on boundary
  function automatic logic [5:0] stepCount(input logic run, input logic [4:0] cnt,
                                           input logic rxTick, input logic arrived);
    logic [5:0] r;
    r = {run, cnt};
    if (rxTick) begin
      r = {1'b1, 5'h00};
    end else if (run && arrived) begin
      r = {1'b0, cnt};
    end else if (run && cnt != 5'h1f) begin
      r = {1'b1, 5'(cnt + 5'h01)};
    end
    return r;
  endfunction

  // next-state logic
  always_comb begin
    logic [5:0] s0;
    logic [5:0] s1;
    s0 = 6'h00;
    s1 = 6'h00;
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    // register writes
    if (req.wrEn) begin
      unique case (req.addr)
        OFF_LINK_ENABLE: st_next.enable = req.wdata[EN_W-1:0];      // [RULE1]
        OFF_SUBCLASS: begin
          if (req.wdata[CLASS_W-1:0] == CLASS_SUB0 || req.wdata[CLASS_W-1:0] == CLASS_SUB1) begin
            st_next.syncClass = req.wdata[CLASS_W-1:0];             // [RULE7]
          end
        end
        OFF_MF_DELAY0: st_next.mfOff0 = req.wdata[FIELD_W-1:0];     // [RULE4]
        OFF_MF_DELAY1: st_next.mfOff1 = req.wdata[FIELD_W-1:0];     // [RULE4]
        OFF_RELEASE0:  st_next.relOff0 = req.wdata[FIELD_W-1:0];    // [RULE5]
        OFF_RELEASE1:  st_next.relOff1 = req.wdata[FIELD_W-1:0];    // [RULE5]
        default: ;
      endcase
    end
    // arrival measurement per link, only while the link is enabled
    s0 = stepCount(st_reg.counting[0], st_reg.skewCnt0, receiveMultiframeTick[0], lastBoundaryArrived[0]);
    s1 = stepCount(st_reg.counting[1], st_reg.skewCnt1, receiveMultiframeTick[1], lastBoundaryArrived[1]);
    if (st_reg.enable[0]) begin
      st_next.counting[0] = s0[5];
      st_next.skewCnt0 = s0[4:0];
      if (st_reg.counting[0] && lastBoundaryArrived[0] && !receiveMultiframeTick[0]) begin
        st_next.skew0 = st_reg.skewCnt0;                            // [RULE3]
      end
    end else begin
      st_next.counting[0] = 1'b0;
    end
    if (st_reg.enable[1]) begin
      st_next.counting[1] = s1[5];
      st_next.skewCnt1 = s1[4:0];
      if (st_reg.counting[1] && lastBoundaryArrived[1] && !receiveMultiframeTick[1]) begin
        st_next.skew1 = st_reg.skewCnt1;                            // [RULE3]
      end
    end else begin
      st_next.counting[1] = 1'b0;
    end
    // register reads, reserved bits zero, unmapped reads zero
    if (req.rdEn) begin
      st_next.rvalid = 1'b1;
      unique case (req.addr)
        OFF_LINK_ENABLE: st_next.rdata = {6'h00, st_reg.enable};
        OFF_SUBCLASS:    st_next.rdata = {5'h00, st_reg.syncClass};
        OFF_ARRIVAL0:    st_next.rdata = pad5(st_reg.skew0);        // [RULE3]
        OFF_ARRIVAL1:    st_next.rdata = pad5(st_reg.skew1);        // [RULE3]
        OFF_MF_DELAY0:   st_next.rdata = pad5(st_reg.mfOff0);
        OFF_MF_DELAY1:   st_next.rdata = pad5(st_reg.mfOff1);
        OFF_RELEASE0:    st_next.rdata = pad5(st_reg.relOff0);
        OFF_RELEASE1:    st_next.rdata = pad5(st_reg.relOff1);
        default:         st_next.rdata = 8'h00;
      endcase
    end
  end

  // state register, frozen while clkEn is low
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.syncClass <= RST_CLASS;                                // [RULE7]
      st_reg.relOff0 <= RST_RELEASE;                                // [RULE5]
      st_reg.relOff1 <= RST_RELEASE;                                // [RULE5]
      st_reg.mfOff0 <= RST_MF_DELAY;
      st_reg.mfOff1 <= RST_MF_DELAY;
      st_reg.enable <= RST_ENABLE;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  // outputs to the bus and the link logic
  assign rdata = st_reg.rdata;
  assign rvalid = st_reg.rvalid;
  assign linkCfgA = '{linkOn: st_reg.enable[0], countFrames: st_reg.syncClass == CLASS_SUB1,
                      mfOffset: st_reg.mfOff0, releaseOffset: st_reg.relOff0};  // [RULE1] [RULE4]
  assign linkCfgB = '{linkOn: st_reg.enable[1], countFrames: st_reg.syncClass == CLASS_SUB1,
                      mfOffset: st_reg.mfOff1, releaseOffset: st_reg.relOff1};  // [RULE1] [RULE4]

  // bus writes land in the link configuration
  a_enable_maps_links: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE1]
    clkEn && req.wrEn && req.addr == OFF_LINK_ENABLE |=> linkCfgA.linkOn == $past(req.wdata[0])
      && linkCfgB.linkOn == $past(req.wdata[1])) else $error("link enable bits misrouted");
  a_offset_write: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE4]
    clkEn && req.wrEn && req.addr == OFF_MF_DELAY1 |=> linkCfgB.mfOffset == $past(req.wdata[4:0]))
    else $error("link 1 tick offset not stored");
  a_offset_write0: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE4]
    clkEn && req.wrEn && req.addr == OFF_MF_DELAY0 |=> linkCfgA.mfOffset == $past(req.wdata[4:0]))
    else $error("link 0 tick offset not stored");
  a_units_follow_class: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE4]
    clkEn && req.wrEn && req.addr == OFF_SUBCLASS && req.wdata[2:0] == CLASS_SUB1
      |=> linkCfgA.countFrames && linkCfgB.countFrames) else $error("offset units wrong");
  a_release_write: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE5]
    clkEn && req.wrEn && req.addr == OFF_RELEASE0 |=> linkCfgA.releaseOffset == $past(req.wdata[4:0]))
    else $error("link 0 release point not stored");
  a_release_write1: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE5]
    clkEn && req.wrEn && req.addr == OFF_RELEASE1 |=> linkCfgB.releaseOffset == $past(req.wdata[4:0]))
    else $error("link 1 release point not stored");

  // class field keeps only the two legal codes
  a_class_legal: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
    st_reg.syncClass == CLASS_SUB0 || st_reg.syncClass == CLASS_SUB1) else $error("illegal class held");
  a_class_illegal_kept: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
    clkEn && req.wrEn && req.addr == OFF_SUBCLASS && req.wdata[2:0] != CLASS_SUB0 && req.wdata[2:0] != CLASS_SUB1
      |=> $stable(st_reg.syncClass)) else $error("illegal class code taken");
  a_class_write: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
    clkEn && req.wrEn && req.addr == OFF_SUBCLASS && req.wdata[2:0] == CLASS_SUB0 ##1 clkEn [*2]
      |-> st_reg.syncClass == CLASS_SUB0 || $past(req.wrEn)) else $error("class 0 not selected");

  // values seen on the first edge after reset
  a_enable_reset: assert property (@(posedge sys_clk) // [RULE1]
    $rose(nrst) |-> !linkCfgA.linkOn && !linkCfgB.linkOn)
    else $error("links enabled out of reset");
  a_release_reset: assert property (@(posedge sys_clk) // [RULE5]
    $rose(nrst) |-> linkCfgA.releaseOffset == RST_RELEASE && linkCfgB.releaseOffset == RST_RELEASE)
    else $error("release point reset value wrong");

  // arrival count: restart on tick, capture on boundary, hold while the link is off
  a_tick_restarts: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE3]
    clkEn && st_reg.enable[0] && receiveMultiframeTick[0] |=> st_reg.counting[0] && st_reg.skewCnt0 == 5'h00)
    else $error("link 0 arrival count not restarted");
  a_skew_capture: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE3]
    clkEn && st_reg.enable[0] && st_reg.counting[0] && lastBoundaryArrived[0] && !receiveMultiframeTick[0]
      |=> st_reg.skew0 == $past(st_reg.skewCnt0)) else $error("link 0 arrival skew not captured");
  a_skew_held_off: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE1]
    clkEn && !st_reg.enable[1] |=> $stable(st_reg.skew1))
    else $error("link 1 skew moved while link off");
  a_skew_read: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE3]
    clkEn && req.rdEn && req.addr == OFF_ARRIVAL1 |=> rvalid && rdata == {3'h0, $past(st_reg.skew1)})
    else $error("link 1 arrival skew read wrong");

  // one full link 1 measurement: tick, five quiet cycles, boundary gives five
  sequence s_tick_b;
    clkEn && st_reg.enable[1] && receiveMultiframeTick[1];
  endsequence
  sequence s_wait_b;
    clkEn && st_reg.enable[1] && !receiveMultiframeTick[1] && !lastBoundaryArrived[1];
  endsequence
  sequence s_edge_b;
    clkEn && st_reg.enable[1] && lastBoundaryArrived[1] && !receiveMultiframeTick[1];
  endsequence
  a_arrival_walk: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE3]
    s_tick_b ##1 s_wait_b [*5] ##1 s_edge_b |=> st_reg.skew1 == 5'h05)
    else $error("link 1 arrival count wrong");

endmodule

// file: jrl_far_tx.sv
// jrl_far_tx: stand-in for the lane transmitter side, giving per-link tick and boundary pulses
// assumes the bench calls frame at a falling edge of sys_clk
`timescale 1ns/1ps
module jrl_far_tx
  import jrl_pkg::*;
(
  // clock
  input  wire logic  sys_clk,
  // timing strobes toward the receiver
  output logic [1:0] rxTick,
  output logic [1:0] boundary
);
  // both strobes idle low
  initial begin
    rxTick = '0;
    boundary = '0;
  end

  // one multiframe: tick now, last boundary gap cycles later, never in the same cycle
  task automatic frame(input int lnk, input int gap);
    rxTick[lnk] = 1'b1;
    @(negedge sys_clk);
    rxTick = '0;
    repeat (gap - 1) @(negedge sys_clk);
    boundary[lnk] = 1'b1;
    @(negedge sys_clk);
    boundary = '0;
  endtask
endmodule

// file: tb_top.sv
// tb_top: self-checking bench for the receiver latency register bank
// assumes jrl_pkg, jrl_regs and jrl_far_tx are compiled first
`timescale 1ns/1ps
module tb_top;
  import jrl_pkg::*;
  logic          sys_clk;
  logic          nrst;
  logic          clkEn;
  jrl_req_t      req;
  logic [7:0]    rdata;
  logic          rvalid;
  logic [1:0]    rxTick;
  logic [1:0]    boundary;
  jrl_link_cfg_t cfgA;
  jrl_link_cfg_t cfgB;
  int            failures;
  int            compares;
  int            cyc;
  logic [7:0]    rstVal [9] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h06, 8'h00};

  jrl_regs jrl_regs_inst (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .req(req), .rdata(rdata),
    .rvalid(rvalid), .localMultiframeTick(2'h0), .receiveMultiframeTick(rxTick),
    .lastBoundaryArrived(boundary), .linkCfgA(cfgA), .linkCfgB(cfgB));
  jrl_far_tx jrl_far_tx_inst (.sys_clk(sys_clk), .rxTick(rxTick), .boundary(boundary));

  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle request driven at the falling edge
  task automatic access(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req = '{wrEn: wr, rdEn: !wr, addr: a, wdata: d};
    @(negedge sys_clk);
    req = '0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    access(1'b0, a, 8'h00);
    check("rvalid", {7'h0, rvalid}, 8'h01);
    check($sformatf("reg %h", a), rdata, exp);
    @(negedge sys_clk);
    check("rvalid end", {7'h0, rvalid}, 8'h00);
  endtask

  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // hang guard, run needs about a hundred cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      give_verdict();
    end
  end

  // test sequence
  initial begin
    nrst = 1'b0;
    clkEn = 1'b1;
    req = '0;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    for (int i = 0; i < 9; i++) rd(12'(12'h300 + i), rstVal[i]);
    $display("test reset values done");
    // parameters first, enables last
    access(1'b1, OFF_MF_DELAY0, 8'hff);
    rd(OFF_MF_DELAY0, 8'h1f);
    check("mfA", {3'h0, cfgA.mfOffset}, 8'h1f);
    access(1'b1, OFF_MF_DELAY1, 8'h0b);
    check("mfB", {3'h0, cfgB.mfOffset}, 8'h0b);
    access(1'b1, OFF_RELEASE0, 8'h0a);
    check("relA", {3'h0, cfgA.releaseOffset}, 8'h0a);
    access(1'b1, OFF_RELEASE1, 8'h00);
    rd(OFF_RELEASE1, 8'h00);
    check("relB", {3'h0, cfgB.releaseOffset}, 8'h00);
    access(1'b1, OFF_SUBCLASS, 8'h00);
    check("framesA", {7'h0, cfgA.countFrames}, 8'h00);
    access(1'b1, OFF_SUBCLASS, 8'h05);
    rd(OFF_SUBCLASS, 8'h00);
    access(1'b1, OFF_SUBCLASS, 8'h01);
    check("framesB", {7'h0, cfgB.countFrames}, 8'h01);
    // a write while the clock enable is low must not land
    clkEn = 1'b0;
    access(1'b1, OFF_RELEASE1, 8'h03);
    clkEn = 1'b1;
    rd(OFF_RELEASE1, 8'h00);
    $display("test parameters done");
    for (int e = 0; e < 4; e++) begin
      access(1'b1, OFF_LINK_ENABLE, 8'(e));
      check("onA", {7'h0, cfgA.linkOn}, 8'(e & 1));
      check("onB", {7'h0, cfgB.linkOn}, 8'(e >> 1));
    end
    $display("test enables done");
    jrl_far_tx_inst.frame(0, 3);
    rd(OFF_ARRIVAL0, 8'h02);
    jrl_far_tx_inst.frame(1, 6);
    rd(OFF_ARRIVAL1, 8'h05);
    access(1'b1, OFF_ARRIVAL1, 8'h1f);
    rd(OFF_ARRIVAL1, 8'h05);
    access(1'b1, OFF_LINK_ENABLE, 8'h01);
    jrl_far_tx_inst.frame(1, 2);
    rd(OFF_ARRIVAL1, 8'h05);
    $display("test arrival done");
    give_verdict();
  end
endmodule
